// >>> rtl/bac_regs.svh
/*
 * Register indices, field positions, reset values and timing counts of the
 * buffer access and arbitration block. Included by the design files; has no
 * logic of its own.
 */
`ifndef BAC_REGS_SVH
`define BAC_REGS_SVH

// Register indices; the APB byte address is four times the index.
`define BAC_IDX_HOST_DATA   8'h50
`define BAC_IDX_HOST_CTRL   8'h52
`define BAC_IDX_DMA_CTRL    8'h53
`define BAC_IDX_RP_LO       8'h5A
`define BAC_IDX_RP_HI       8'h5B
`define BAC_IDX_WP_LO       8'h5C
`define BAC_IDX_WP_HI       8'h5D
`define BAC_IDX_BUF_ACCESS  8'h70

// Host interface control fields.
`define BAC_HC_ARB_REQ      0
`define BAC_HC_BIE_EN       2
`define BAC_HC_BOE_EN       3
`define BAC_HC_BUSY_STAT    4

// DMA control fields.
`define BAC_DC_WRITE_LATCH  2
`define BAC_DC_READ_LATCH   3
`define BAC_DC_DIRECTION    4

`define BAC_HOST_CTRL_RST   8'h00
`define BAC_DMA_CTRL_RST    8'h00
`define BAC_PTR_RST         16'h0000

// Least bus-free time before busy-out may rise, in ns, and in pclk cycles.
`define BAC_CLK_NS          5
`define BAC_BUS_FREE_NS     5
`define BAC_BUS_FREE_CYC    ((`BAC_BUS_FREE_NS + `BAC_CLK_NS - 1) / `BAC_CLK_NS)

`endif

// >>> rtl/bac_pkg.sv
/*
 * Types of the buffer access and arbitration block.
 * Assumes nothing of its surroundings.
 */
package bac_pkg;

    typedef enum logic [2:0] {
        BAC_SEQ_IDLE,
        BAC_SEQ_MEM,
        BAC_SEQ_HIN,
        BAC_SEQ_LATCH,
        BAC_SEQ_ACK
    } bac_seq_t;

    typedef enum logic [1:0] {
        BAC_ARB_IDLE,
        BAC_ARB_WAIT,
        BAC_ARB_FREE,
        BAC_ARB_BUSY
    } bac_arb_t;

endpackage

// >>> rtl/bac_arb.sv
/*
 * Two-wire arbitration helper: waits for a free bus, then drives busy-out.
 * Assumes busy_in, sel_in and sel_out are already synchronised to pclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bac_regs.svh"

module bac_arb (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic req_pending,
    input  wire logic busy_in,
    input  wire logic sel_in,
    input  wire logic sel_out,
    output logic      busy_out,
    output logic      arb_done
);

    bac_pkg::bac_arb_t state_q;
    bac_pkg::bac_arb_t state_d;
    logic [3:0]        free_cnt_q;
    logic [3:0]        free_cnt_d;
    logic              bus_free;

    assign bus_free = !busy_in && !sel_in;

    always_comb begin
        state_d    = state_q;
        free_cnt_d = free_cnt_q;
        arb_done   = 1'b0;
        if (!req_pending) begin
            state_d = bac_pkg::BAC_ARB_IDLE;
        end else begin
            unique case (state_q)
                bac_pkg::BAC_ARB_IDLE: begin
                    state_d = bac_pkg::BAC_ARB_WAIT;
                end
                bac_pkg::BAC_ARB_WAIT: begin
                    if (bus_free) begin
                        state_d    = bac_pkg::BAC_ARB_FREE;
                        free_cnt_d = 4'h1;
                    end
                end
                bac_pkg::BAC_ARB_FREE: begin
                    if (!bus_free) begin
                        state_d = bac_pkg::BAC_ARB_WAIT;
                    end else if (free_cnt_q >= 4'(`BAC_BUS_FREE_CYC)) begin
                        state_d = bac_pkg::BAC_ARB_BUSY;
                    end else begin
                        free_cnt_d = free_cnt_q + 4'h1;
                    end
                end
                bac_pkg::BAC_ARB_BUSY: begin
                    if (sel_out || sel_in || busy_in) begin
                        state_d  = bac_pkg::BAC_ARB_IDLE;
                        arb_done = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= bac_pkg::BAC_ARB_IDLE;
            free_cnt_q <= 4'h0;
        end else begin
            state_q    <= state_d;
            free_cnt_q <= free_cnt_d;
        end
    end

    assign busy_out = (state_q == bac_pkg::BAC_ARB_BUSY);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_idle_quiet: assert property (!req_pending |-> ##1 !busy_out)
        else $error("busy-out rose without a pending request");
    a_free_before_busy: assert property ($rose(busy_out) |-> $past(bus_free) && $past(bus_free, 2))
        else $error("busy-out rose before a full free cycle");
    a_wait_busy_bus: assert property (req_pending && !busy_out && !bus_free |=> !busy_out)
        else $error("busy-out rose while the bus was busy");
    a_busy_release: assert property (busy_out && req_pending && (sel_in || busy_in || sel_out) |=> !busy_out)
        else $error("busy-out held after contention");
    a_busy_hold: assert property (busy_out && req_pending && !sel_in && !busy_in && !sel_out |=> busy_out)
        else $error("busy-out dropped without cause");
    c_arb_won: cover property (!busy_out ##1 busy_out [*3] ##1 !busy_out);

endmodule
`default_nettype wire

// >>> rtl/bac_top.sv
/*
 * Buffer access and arbitration block: APB register slave, direct processor
 * access to buffer RAM, host data bus strobes, port request priority and the
 * arbitration helper. Assumes buffer RAM and the host data latch answer
 * within one pclk cycle of their strobes; port request, busy-in, select-in and select-out are asynchronous.
 */
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "bac_regs.svh"

// Overview of operation
// - Buffer access takes its address from read pointer, or write pointer when direction set.
// - Buffer access by the processor never advances either pointer.
// - Writing one to the arbitration-request bit makes a request pending.
// - A pending request waits until busy-in and select-in are both inactive.
// - Busy-out rises only after one full free clock period.
// - Busy-out holds until select-out, select-in, busy-in, or software clears it.
// - Port request has priority over processor buffer cycles and host reads; idle request frees the cycle.
// - An active port request disables bus-in-enable in every cycle that it is active.
// - Host data write with output enable set pulses latch strobe, then raises bus-out-enable until the bit is cleared.
// - Direction set writes port data at write pointer; clear reads at read pointer.
// - Buffer read asserts memory select; buffer write adds buffer write enable.
// - Latch and bus-out-enable occur only when the output-enable bit was set.
module bac_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [15:0] buf_addr,
    output logic      [7:0]  buf_wdata,
    input  wire logic [7:0]  buf_rdata,
    output logic             memory_select,
    output logic             buf_write_en,
    input  wire logic        port_req,
    output logic             port_slot,
    input  wire logic [7:0]  host_data_in,
    output logic      [7:0]  host_data_out,
    output logic             bus_in_enable,
    output logic             bus_out_enable,
    output logic             latch_strobe,
    input  wire logic        busy_in,
    input  wire logic        sel_in,
    input  wire logic        sel_out,
    output logic             busy_out
);

    function automatic logic idx_is(input logic [11:0] addr, input logic [7:0] idx);
        idx_is = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) && (addr[9:2] == idx);
    endfunction

    // Two-flop synchronisers for the asynchronous pins.
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic       port_req_s;
    logic       busy_in_s;
    logic       sel_in_s;
    logic       sel_out_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
        end else begin
            pin_meta_q <= {sel_out, sel_in, busy_in, port_req};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign port_req_s = pin_sync_q[0];
    assign busy_in_s  = pin_sync_q[1];
    assign sel_in_s   = pin_sync_q[2];
    assign sel_out_s  = pin_sync_q[3];

    // Registers and sequencer.
    bac_pkg::bac_seq_t seq_q;
    bac_pkg::bac_seq_t seq_d;
    logic [7:0]  host_ctrl_q;
    logic [7:0]  host_ctrl_d;
    logic [7:0]  dma_ctrl_q;
    logic [7:0]  dma_ctrl_d;
    logic [15:0] rp_q;
    logic [15:0] rp_d;
    logic [15:0] wp_q;
    logic [15:0] wp_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [7:0]  host_out_q;
    logic [7:0]  host_out_d;
    logic        boe_q;
    logic        boe_d;
    logic        setup;
    logic        commit;
    logic        mapped;
    logic        direction;
    logic        cpu_mem;
    logic        port_xfer;
    logic        arb_done;

    assign setup     = psel && !penable && (seq_q == bac_pkg::BAC_SEQ_IDLE);
    assign commit    = psel && penable && pready;
    assign direction = dma_ctrl_q[`BAC_DC_DIRECTION];
    assign mapped    = idx_is(paddr, `BAC_IDX_HOST_DATA) || idx_is(paddr, `BAC_IDX_HOST_CTRL)
                    || idx_is(paddr, `BAC_IDX_DMA_CTRL) || idx_is(paddr, `BAC_IDX_RP_LO)
                    || idx_is(paddr, `BAC_IDX_RP_HI) || idx_is(paddr, `BAC_IDX_WP_LO)
                    || idx_is(paddr, `BAC_IDX_WP_HI) || idx_is(paddr, `BAC_IDX_BUF_ACCESS);
    // The processor's buffer cycle yields to a port transfer, which cannot wait.
    assign port_xfer = port_req_s;
    assign cpu_mem   = (seq_q == bac_pkg::BAC_SEQ_MEM) && !port_xfer;

    always_comb begin
        seq_d       = seq_q;
        host_ctrl_d = host_ctrl_q;
        dma_ctrl_d  = dma_ctrl_q;
        rp_d        = rp_q;
        wp_d        = wp_q;
        prdata_d    = prdata_q;
        host_out_d  = host_out_q;
        boe_d       = boe_q;
        unique case (seq_q)
            bac_pkg::BAC_SEQ_IDLE: begin
                if (setup) begin
                    prdata_d = 32'h0000_0000;
                    if (idx_is(paddr, `BAC_IDX_BUF_ACCESS)) begin
                        seq_d = bac_pkg::BAC_SEQ_MEM;
                    end else if (idx_is(paddr, `BAC_IDX_HOST_DATA) && !pwrite) begin
                        seq_d = bac_pkg::BAC_SEQ_HIN;
                    end else if (idx_is(paddr, `BAC_IDX_HOST_DATA) && host_ctrl_q[`BAC_HC_BOE_EN]) begin
                        host_out_d = pwdata[7:0];
                        seq_d      = bac_pkg::BAC_SEQ_LATCH;
                    end else begin
                        seq_d = bac_pkg::BAC_SEQ_ACK;
                        if (idx_is(paddr, `BAC_IDX_HOST_CTRL)) begin
                            prdata_d[7:0] = host_ctrl_q;
                            prdata_d[`BAC_HC_BUSY_STAT] = busy_out;
                        end
                        if (idx_is(paddr, `BAC_IDX_DMA_CTRL)) begin
                            prdata_d[7:0] = dma_ctrl_q;
                        end
                        if (idx_is(paddr, `BAC_IDX_RP_LO)) begin
                            prdata_d[7:0] = rp_q[7:0];
                        end
                        if (idx_is(paddr, `BAC_IDX_RP_HI)) begin
                            prdata_d[7:0] = rp_q[15:8];
                        end
                        if (idx_is(paddr, `BAC_IDX_WP_LO)) begin
                            prdata_d[7:0] = wp_q[7:0];
                        end
                        if (idx_is(paddr, `BAC_IDX_WP_HI)) begin
                            prdata_d[7:0] = wp_q[15:8];
                        end
                    end
                end
            end
            bac_pkg::BAC_SEQ_MEM: begin
                if (!port_xfer) begin
                    prdata_d = {24'h00_0000, buf_rdata};
                    seq_d    = bac_pkg::BAC_SEQ_ACK;
                end
            end
            bac_pkg::BAC_SEQ_HIN: begin
                if (!port_xfer) begin
                    prdata_d = {24'h00_0000, host_data_in};
                    seq_d    = bac_pkg::BAC_SEQ_ACK;
                end
            end
            bac_pkg::BAC_SEQ_LATCH: begin
                boe_d = 1'b1;
                seq_d = bac_pkg::BAC_SEQ_ACK;
            end
            bac_pkg::BAC_SEQ_ACK: begin
                if (commit) begin
                    seq_d = bac_pkg::BAC_SEQ_IDLE;
                end
            end
            default: begin
                seq_d = bac_pkg::BAC_SEQ_IDLE;
            end
        endcase
        if (commit && pwrite) begin
            if (idx_is(paddr, `BAC_IDX_HOST_CTRL)) begin
                host_ctrl_d = pwdata[7:0];
                host_ctrl_d[`BAC_HC_BUSY_STAT] = 1'b0;
            end
            if (idx_is(paddr, `BAC_IDX_DMA_CTRL)) begin
                dma_ctrl_d = pwdata[7:0];
            end
            if (idx_is(paddr, `BAC_IDX_RP_LO)) begin
                rp_d[7:0] = pwdata[7:0];
            end
            if (idx_is(paddr, `BAC_IDX_RP_HI)) begin
                rp_d[15:8] = pwdata[7:0];
            end
            if (idx_is(paddr, `BAC_IDX_WP_LO)) begin
                wp_d[7:0] = pwdata[7:0];
            end
            if (idx_is(paddr, `BAC_IDX_WP_HI)) begin
                wp_d[15:8] = pwdata[7:0];
            end
        end
        // A request that ends in the same cycle it is rewritten keeps the write.
        if (arb_done && !(commit && pwrite && idx_is(paddr, `BAC_IDX_HOST_CTRL))) begin
            host_ctrl_d[`BAC_HC_ARB_REQ] = 1'b0;
        end
        if (!host_ctrl_d[`BAC_HC_BOE_EN]) begin
            boe_d = 1'b0;
        end
        // Only port transfers advance a pointer; processor buffer cycles do not.
        if (port_xfer) begin
            if (direction) begin
                wp_d = wp_d + 16'h0001;
            end else begin
                rp_d = rp_d + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q       <= bac_pkg::BAC_SEQ_IDLE;
            host_ctrl_q <= `BAC_HOST_CTRL_RST;
            dma_ctrl_q  <= `BAC_DMA_CTRL_RST;
            rp_q        <= `BAC_PTR_RST;
            wp_q        <= `BAC_PTR_RST;
            prdata_q    <= 32'h0000_0000;
            host_out_q  <= 8'h00;
            boe_q       <= 1'b0;
        end else begin
            seq_q       <= seq_d;
            host_ctrl_q <= host_ctrl_d;
            dma_ctrl_q  <= dma_ctrl_d;
            rp_q        <= rp_d;
            wp_q        <= wp_d;
            prdata_q    <= prdata_d;
            host_out_q  <= host_out_d;
            boe_q       <= boe_d;
        end
    end

    assign prdata         = prdata_q;
    assign pready         = (seq_q == bac_pkg::BAC_SEQ_ACK);
    assign pslverr        = pready && !mapped;
    assign buf_addr       = direction ? wp_q : rp_q;
    assign buf_wdata      = pwdata[7:0];
    assign memory_select  = cpu_mem || port_xfer;
    assign buf_write_en   = (cpu_mem && pwrite) || (port_xfer && direction);
    assign port_slot      = port_xfer;
    assign host_data_out  = host_out_q;
    assign latch_strobe   = (seq_q == bac_pkg::BAC_SEQ_LATCH);
    assign bus_out_enable = boe_q;
    assign bus_in_enable  = (seq_q == bac_pkg::BAC_SEQ_HIN) && host_ctrl_q[`BAC_HC_BIE_EN] && !port_xfer;

    bac_arb u_arb (
        .pclk        (pclk),
        .presetn     (presetn),
        .req_pending (host_ctrl_q[`BAC_HC_ARB_REQ]),
        .busy_in     (busy_in_s),
        .sel_in      (sel_in_s),
        .sel_out     (sel_out_s),
        .busy_out    (busy_out),
        .arb_done    (arb_done)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_addr_select: assert property (memory_select |-> buf_addr == (dma_ctrl_q[4] ? wp_q : rp_q))
        else $error("buffer address from wrong pointer");
    a_ptr_hold: assert property (cpu_mem |=> $stable(rp_q) && $stable(wp_q))
        else $error("pointer moved on processor buffer access");
    a_mem_strobes: assert property (cpu_mem |-> memory_select && (buf_write_en == pwrite))
        else $error("buffer strobes wrong on processor access");
    a_port_dir: assert property (port_xfer && direction && !(commit && pwrite) |=> wp_q == $past(wp_q) + 16'h0001)
        else $error("write pointer did not advance on port input");
    a_bie_block: assert property (port_req_s |-> !bus_in_enable)
        else $error("bus-in-enable active beside port request");
    a_port_first: assert property (port_req_s |-> !cpu_mem && memory_select)
        else $error("port request lost its priority");
    a_latch_then_boe: assert property (latch_strobe |=> !latch_strobe && bus_out_enable)
        else $error("bus-out-enable did not follow latch strobe");
    a_latch_gated: assert property (latch_strobe |-> host_ctrl_q[3])
        else $error("latch strobe without output enable set");
    c_buf_read: cover property (cpu_mem && !pwrite ##1 pready);
    c_host_write: cover property (latch_strobe ##1 pready && bus_out_enable);
    c_port_stall: cover property (seq_q == bac_pkg::BAC_SEQ_MEM && port_xfer ##1 cpu_mem);

endmodule
`default_nettype wire

// >>> bench/bac_ram_model.sv
/*
 * Behavioural buffer RAM that stands at the far side of the buffer access block.
 * Assumes one pclk and byte-wide data; only the low eight address bits are decoded.
 */
`timescale 1ns/10ps
`default_nettype none

module bac_ram_model (
    input  wire logic        pclk,
    input  wire logic [15:0] buf_addr,
    input  wire logic [7:0]  buf_wdata,
    input  wire logic        memory_select,
    input  wire logic        buf_write_en,
    output logic      [7:0]  buf_rdata
);
    logic [7:0] mem [256];
    logic [7:0] last_q;

    initial begin
        last_q = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end

    always @(posedge pclk) begin
        if (memory_select && buf_write_en) begin
            mem[buf_addr[7:0]] <= buf_wdata;
        end
        if (memory_select) begin
            last_q <= mem[buf_addr[7:0]];
        end
    end

    // An unselected RAM shows the inverse of its last byte, so stale data cannot pass.
    assign buf_rdata = memory_select ? mem[buf_addr[7:0]] : ~last_q;
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
/*
 * Self-checking testbench of the buffer access and arbitration block.
 * Assumes the RAM model beside it and the register indices of the design header.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bac_regs.svh"

module tb_top;
    localparam logic [11:0] A_HD = {2'b00, `BAC_IDX_HOST_DATA, 2'b00};
    localparam logic [11:0] A_HC = {2'b00, `BAC_IDX_HOST_CTRL, 2'b00};
    localparam logic [11:0] A_DC = {2'b00, `BAC_IDX_DMA_CTRL, 2'b00};
    localparam logic [11:0] A_RL = {2'b00, `BAC_IDX_RP_LO, 2'b00};
    localparam logic [11:0] A_RH = {2'b00, `BAC_IDX_RP_HI, 2'b00};
    localparam logic [11:0] A_WL = {2'b00, `BAC_IDX_WP_LO, 2'b00};
    localparam logic [11:0] A_WH = {2'b00, `BAC_IDX_WP_HI, 2'b00};
    localparam logic [11:0] A_BF = {2'b00, `BAC_IDX_BUF_ACCESS, 2'b00};

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] buf_addr;
    logic [7:0]  buf_wdata, buf_rdata, host_data_out;
    logic        memory_select, buf_write_en, port_req, port_slot, e;
    logic        bus_in_enable, bus_out_enable, latch_strobe;
    logic        busy_in, sel_in, sel_out, busy_out;
    int          mismatches, checks_done, we_n, ls_n, ps_n, bie_n, v_port, v_lb, n, k;

    bac_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata),
        .memory_select(memory_select), .buf_write_en(buf_write_en), .port_req(port_req),
        .port_slot(port_slot), .host_data_in(8'h96), .host_data_out(host_data_out),
        .bus_in_enable(bus_in_enable), .bus_out_enable(bus_out_enable), .latch_strobe(latch_strobe),
        .busy_in(busy_in), .sel_in(sel_in), .sel_out(sel_out), .busy_out(busy_out));

    bac_ram_model ram (.pclk(pclk), .buf_addr(buf_addr), .buf_wdata(buf_wdata),
        .memory_select(memory_select), .buf_write_en(buf_write_en), .buf_rdata(buf_rdata));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Outputs are sampled mid-cycle, where combinational strobes have settled.
    always @(negedge pclk) begin
        if (buf_write_en) we_n++;
        if (latch_strobe) ls_n++;
        if (port_slot) ps_n++;
        if (bus_in_enable) bie_n++;
        if (port_slot && (bus_in_enable || !memory_select)) v_port++;
        if (latch_strobe && bus_out_enable) v_lb++;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at a rising edge.
    // The task returns mid-cycle, so a register written by it has already landed.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int c;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (pready !== 1'b1 && c < 100);
        r = prdata;
        e = pslverr;
        chk("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic port_pulse;
        @(posedge pclk);
        port_req <= 1'b1;
        @(posedge pclk);
        port_req <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    task automatic wait_busy(input logic lvl);
        int c;
        c = 0;
        while (busy_out !== lvl && c < 12) begin
            @(negedge pclk);
            c++;
        end
        chk("busy_out", {31'h0, lvl}, {31'h0, busy_out});
    endtask

    initial begin
        #(20000 * 5);
        mismatches++;
        $display("ERROR watchdog expired");
        report_and_stop();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, port_req, busy_in, sel_in, sel_out} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("buf_addr", 32'h0, {16'h0, buf_addr});
        chk("busy_out", 32'h0, {31'h0, busy_out});
        $display("test reset done");

        apb(1, A_RL, 32'h43); apb(1, A_RH, 32'h0); apb(1, A_WL, 32'h21); apb(1, A_WH, 32'h0);
        apb(1, A_DC, 32'h10);
        chk("buf_addr", 32'h21, {16'h0, buf_addr});
        k = we_n;
        apb(1, A_BF, 32'hA5);
        chk("write enable", 32'h1, {31'h0, we_n != k});
        k = we_n;
        apb(0, A_BF, 32'h0);
        chk("buffer byte", 32'hA5, {24'h0, r[7:0]});
        chk("write enable", 32'h0, {31'h0, we_n != k});
        apb(0, A_WL, 32'h0);
        chk("wp lo", 32'h21, {24'h0, r[7:0]});
        apb(1, A_DC, 32'h00);
        chk("buf_addr", 32'h43, {16'h0, buf_addr});
        apb(0, A_BF, 32'h0);
        chk("buffer byte", 32'h43 ^ 32'h5A, {24'h0, r[7:0]});
        apb(0, A_RL, 32'h0);
        chk("rp lo", 32'h43, {24'h0, r[7:0]});
        apb(0, 12'h000, 32'h0);
        chk("pslverr", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        apb(1, A_WL, 32'h43);
        apb(1, A_DC, 32'h10);
        apb(0, A_BF, 32'h0);
        chk("buffer byte", 32'h43 ^ 32'h5A, {24'h0, r[7:0]});
        apb(1, A_WL, 32'h21);
        apb(1, A_DC, 32'h00);
        $display("test buffer access done");

        apb(1, A_HC, 32'h00); apb(1, A_HD, 32'h3C);
        chk("latch strobes", 32'h0, ls_n);
        chk("bus_out_enable", 32'h0, {31'h0, bus_out_enable});
        apb(1, A_HC, 32'h08); apb(1, A_HD, 32'h3C);
        chk("latch strobes", 32'h1, ls_n);
        chk("bus_out_enable", 32'h1, {31'h0, bus_out_enable});
        chk("strobe order", 32'h0, v_lb);
        chk("host_data_out", 32'h3C, {24'h0, host_data_out});
        apb(1, A_HC, 32'h04);
        $display("test host data done");

        k = ps_n;
        // The port request is timed to land in the host read's data cycle and stall it.
        fork
            begin
                @(posedge pclk);
                apb(0, A_HD, 32'h0);
            end
            port_pulse();
        join
        chk("port slots", 32'h1, ps_n - k);
        chk("bus_in_enable seen", 32'h1, {31'h0, bie_n > 0});
        chk("port overlap", 32'h0, v_port);
        apb(0, A_RL, 32'h0);
        chk("rp lo", 32'h44, {24'h0, r[7:0]});
        apb(1, A_DC, 32'h10);
        port_pulse();
        apb(0, A_WL, 32'h0);
        chk("wp lo", 32'h22, {24'h0, r[7:0]});
        $display("test port priority done");

        for (n = 0; n < 4; n++) begin
            @(posedge pclk);
            sel_in <= 1'b1;
            apb(1, A_HC, 32'h01);
            repeat (6) @(negedge pclk);
            chk("busy_out", 32'h0, {31'h0, busy_out});
            @(posedge pclk);
            sel_in <= 1'b0;
            @(negedge pclk);
            chk("busy_out", 32'h0, {31'h0, busy_out});
            wait_busy(1'b1);
            @(posedge pclk);
            case (n)
                0: busy_in <= 1'b1;
                1: sel_in <= 1'b1;
                2: sel_out <= 1'b1;
                default: apb(1, A_HC, 32'h00);
            endcase
            wait_busy(1'b0);
            @(posedge pclk);
            {busy_in, sel_in, sel_out} <= 3'b000;
            apb(0, A_HC, 32'h0);
            chk("host ctrl", 32'h0, r & 32'h11);
            repeat (8) @(negedge pclk);
            chk("busy_out", 32'h0, {31'h0, busy_out});
        end
        $display("test arbitration done");
        report_and_stop();
    end
endmodule

`default_nettype wire
